// ### hdl/cma_multiply_adder.sv
// Configurable multiply-adder with optional register stages
//
// What this block does
// - One to four multipliers, never more than four.
// - Operand A, operand B and result widths are parameters from 1 to 256.
// - A operands unsigned, signed, or chosen by the A sign input.
// - B operands unsigned, signed, or chosen by the B sign input.
// - Each sign input has optional input and pipeline registers, any clock.
// - Each control register clears from one of the four clears, or none.
// - Second product added or subtracted, fixed or by first-pair input.
// - Fourth product added or subtracted, fixed or by second-pair input.
// - Each add/subtract input has optional input and pipeline registers.
// - Adder result optionally registered, selectable clock and clear.
// - Each multiplier's A and B inputs optionally registered, per index.
// - Each operand comes from its bus slice or the shift chain.
// - Each product optionally registered before the adder.
// - Last multiplier's A and B optionally presented as shift outputs.
// - Operand buses are count times width, one slice per multiplier.
// - Four clocks, any register uses any, each with optional enable.
// - Four clears; the fourth exists only when configured.
// - Optional mode where every multiplier shares the first settings.
// - The combined sum drives the result bus at the result width.
// - With saturation on, overflow flag rises whenever result overflows.
`default_nettype none

module cma_stage #(
  parameter int W = 1,
  parameter cma_pkg::cma_reg_t CFG = cma_pkg::REG_OFF,
  parameter bit HAS_CLR3 = 1'b0
) (
  input wire logic sys_clk,
  input wire logic syncClear,
  input wire logic [cma_pkg::NUM_CLK-1:0] clkEn,
  input wire logic [cma_pkg::NUM_CLK-1:0] asyncClear,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import cma_pkg::*;
  localparam bit CLR_OK = (CFG.clr < CLR_NONE) &&
    ((CFG.clr != CLR_FOURTH) || HAS_CLR3);

  generate
    if (CFG.used) begin : g_reg
      logic clrLine;
      logic [W-1:0] held;
      if (CLR_OK) begin : g_clr
        assign clrLine = asyncClear[CFG.clr[1:0]];
      end else begin : g_noclr
        assign clrLine = 1'b0;
      end
      always_ff @(posedge sys_clk or posedge clrLine) begin
        if (clrLine) begin
          held <= '0;
        end else if (syncClear) begin
          held <= '0;
        end else if (clkEn[CFG.clk]) begin
          held <= d;
        end
      end
      assign q = held;
    end else begin : g_pass
      assign q = d;
    end
  endgenerate
endmodule : cma_stage

module cma_multiply_adder #(
  parameter int MULTIPLIER_COUNT = 4,
  parameter int A_WIDTH = 16,
  parameter int B_WIDTH = 16,
  parameter int R_WIDTH = 34,
  parameter bit ALL_SIMILAR = 1'b0,
  parameter bit HAS_CLEAR3 = 1'b0,
  parameter bit HAS_CLOCK_ENABLE = 1'b1,
  parameter cma_pkg::cma_rep_t REP_A = cma_pkg::REP_UNSIGNED,
  parameter cma_pkg::cma_rep_t REP_B = cma_pkg::REP_UNSIGNED,
  parameter cma_pkg::cma_dir_t DIR_FIRST = cma_pkg::DIR_ADD,
  parameter cma_pkg::cma_dir_t DIR_SECOND = cma_pkg::DIR_ADD,
  parameter cma_pkg::cma_reg_t [3:0] CTL_IN = '0,
  parameter cma_pkg::cma_reg_t [3:0] CTL_PIPE = '0,
  parameter cma_pkg::cma_reg_t [3:0] IN_A = '0,
  parameter cma_pkg::cma_reg_t [3:0] IN_B = '0,
  parameter cma_pkg::cma_reg_t [3:0] PROD_REG = '0,
  parameter cma_pkg::cma_reg_t OUT_REG = cma_pkg::REG_OFF,
  parameter logic [3:0] SRC_A_CHAIN = 4'h0,
  parameter logic [3:0] SRC_B_CHAIN = 4'h0,
  parameter bit SHIFT_OUT_A = 1'b0,
  parameter bit SHIFT_OUT_B = 1'b0,
  parameter bit SATURATE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [cma_pkg::NUM_CLK-1:0] clockTick,
  input wire logic [cma_pkg::NUM_CLK-1:0] clockEnable,
  input wire logic [cma_pkg::NUM_CLK-1:0] asyncClear,
  input wire logic [MULTIPLIER_COUNT*A_WIDTH-1:0] dataA,
  input wire logic [MULTIPLIER_COUNT*B_WIDTH-1:0] dataB,
  input wire logic [A_WIDTH-1:0] shiftInA,
  input wire logic [B_WIDTH-1:0] shiftInB,
  input wire logic signA,
  input wire logic signB,
  input wire logic firstPairAddNotSub,
  input wire logic secondPairAddNotSub,
  output logic [R_WIDTH-1:0] result,
  output logic overflow,
  output logic [A_WIDTH-1:0] shiftOutA,
  output logic [B_WIDTH-1:0] shiftOutB,
  input wire cma_pkg::cma_wb_req_t wbReq,
  output logic wbAck,
  output logic [cma_pkg::WB_DW-1:0] wbDatOut
);
  import cma_pkg::*;
  // Counts above four are clamped rather than rejected
  localparam int NM = (MULTIPLIER_COUNT > MAX_MULT) ? MAX_MULT :
    MULTIPLIER_COUNT;
  localparam int PW = A_WIDTH + B_WIDTH + 2;
  // Two guard bits keep a four-term sum exact before saturation
  localparam int SW = PW + 2;
  localparam int EW = (SW > R_WIDTH) ? SW : R_WIDTH;

  logic softClear;
  logic freeze;
  logic stickyOv;
  logic syncClear;
  logic [NUM_CLK-1:0] clkEn;

  assign syncClear = rst | softClear;
  // Freeze gates every tick so software can hold the pipeline
  assign clkEn = clockTick & (HAS_CLOCK_ENABLE ? clockEnable : '1) &
    {NUM_CLK{~freeze}};

  logic [NUM_CTL-1:0] ctlRaw;
  wire logic [NUM_CTL-1:0] ctlMid;
  wire logic [NUM_CTL-1:0] ctlOut;
  assign ctlRaw = {secondPairAddNotSub, firstPairAddNotSub, signB, signA};

  for (genvar c = 0; c < NUM_CTL; c++) begin : g_ctl
    cma_stage #(.W(1), .CFG(CTL_IN[c]), .HAS_CLR3(HAS_CLEAR3)) u_in (
      .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
      .asyncClear(asyncClear), .d(ctlRaw[c]), .q(ctlMid[c]));
    cma_stage #(.W(1), .CFG(CTL_PIPE[c]), .HAS_CLR3(HAS_CLEAR3)) u_pipe (
      .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
      .asyncClear(asyncClear), .d(ctlMid[c]), .q(ctlOut[c]));
  end

  logic sgnA;
  logic sgnB;
  assign sgnA = (REP_A == REP_SIGNED) ||
    ((REP_A == REP_VARIABLE) && ctlOut[CTL_SIGN_A]);
  assign sgnB = (REP_B == REP_SIGNED) ||
    ((REP_B == REP_VARIABLE) && ctlOut[CTL_SIGN_B]);

  wire logic [A_WIDTH-1:0] aSrc [MAX_MULT];
  wire logic [A_WIDTH-1:0] aOp [MAX_MULT];
  wire logic [B_WIDTH-1:0] bSrc [MAX_MULT];
  wire logic [B_WIDTH-1:0] bOp [MAX_MULT];
  wire logic signed [PW-1:0] prod [MAX_MULT];
  wire logic signed [PW-1:0] prodOut [MAX_MULT];
  wire logic signed [EW-1:0] prodExt [MAX_MULT];

  for (genvar i = 0; i < MAX_MULT; i++) begin : g_mult
    if (i < NM) begin : g_on
      localparam int K = ALL_SIMILAR ? 0 : i;
      if (!SRC_A_CHAIN[K]) begin : g_abus
        assign aSrc[i] = dataA[i*A_WIDTH +: A_WIDTH];
      end else if (i == 0) begin : g_ashin
        assign aSrc[i] = shiftInA;
      end else begin : g_achain
        assign aSrc[i] = aOp[i-1];
      end
      if (!SRC_B_CHAIN[K]) begin : g_bbus
        assign bSrc[i] = dataB[i*B_WIDTH +: B_WIDTH];
      end else if (i == 0) begin : g_bshin
        assign bSrc[i] = shiftInB;
      end else begin : g_bchain
        assign bSrc[i] = bOp[i-1];
      end
      cma_stage #(.W(A_WIDTH), .CFG(IN_A[K]), .HAS_CLR3(HAS_CLEAR3)) u_a (
        .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
        .asyncClear(asyncClear), .d(aSrc[i]), .q(aOp[i]));
      cma_stage #(.W(B_WIDTH), .CFG(IN_B[K]), .HAS_CLR3(HAS_CLEAR3)) u_b (
        .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
        .asyncClear(asyncClear), .d(bSrc[i]), .q(bOp[i]));
      // An extra top bit makes one signed multiplier cover both formats
      assign prod[i] = $signed({sgnA & aOp[i][A_WIDTH-1], aOp[i]}) *
        $signed({sgnB & bOp[i][B_WIDTH-1], bOp[i]});
      cma_stage #(.W(PW), .CFG(PROD_REG[K]), .HAS_CLR3(HAS_CLEAR3)) u_p (
        .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
        .asyncClear(asyncClear), .d(prod[i]), .q(prodOut[i]));
      assign prodExt[i] = {{(EW-PW){prodOut[i][PW-1]}}, prodOut[i]};
    end else begin : g_off
      assign prodExt[i] = '0;
    end
  end

  logic addFirst;
  logic addSecond;
  logic signed [EW-1:0] sum;
  logic fits;
  logic [R_WIDTH-1:0] posMax;
  logic [R_WIDTH:0] outNext;
  wire logic [R_WIDTH:0] outQ;

  assign addFirst = (DIR_FIRST == DIR_ADD) ||
    ((DIR_FIRST == DIR_VARIABLE) && ctlOut[CTL_FIRST]);
  assign addSecond = (DIR_SECOND == DIR_ADD) ||
    ((DIR_SECOND == DIR_VARIABLE) && ctlOut[CTL_SECOND]);
  // Third product always adds; the fourth follows the second-pair control
  assign sum = (addFirst ? prodExt[0] + prodExt[1] : prodExt[0] - prodExt[1])
    + (addSecond ? prodExt[2] + prodExt[3] : prodExt[2] - prodExt[3]);
  assign fits = (&sum[EW-1:R_WIDTH-1]) | ~(|sum[EW-1:R_WIDTH-1]);
  assign posMax = {R_WIDTH{1'b1}} >> 1;

  always_comb begin
    outNext = {1'b0, sum[R_WIDTH-1:0]};
    if (SATURATE && !fits) begin
      outNext = {1'b1, sum[EW-1] ? ~posMax : posMax};
    end
  end

  cma_stage #(.W(R_WIDTH + 1), .CFG(OUT_REG), .HAS_CLR3(HAS_CLEAR3)) u_out (
    .sys_clk(sys_clk), .syncClear(syncClear), .clkEn(clkEn),
    .asyncClear(asyncClear), .d(outNext), .q(outQ));

  assign result = outQ[R_WIDTH-1:0];
  assign overflow = outQ[R_WIDTH];
  assign shiftOutA = SHIFT_OUT_A ? aOp[NM-1] : '0;
  assign shiftOutB = SHIFT_OUT_B ? bOp[NM-1] : '0;

  logic wbHit;
  logic wbWrite;
  logic stickyClr;
  logic [WB_DW-1:0] rdNext;

  assign wbHit = wbReq.cyc && wbReq.stb && !wbAck;
  assign wbWrite = wbHit && wbReq.we && wbReq.sel[0];
  assign stickyClr = wbWrite && (wbReq.adr == ADR_STATUS) &&
    wbReq.dat[ST_STICKY];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbHit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      softClear <= 1'b0;
      freeze <= 1'b0;
    end else begin
      softClear <= 1'b0;
      if (wbWrite && (wbReq.adr == ADR_CTRL)) begin
        softClear <= wbReq.dat[CTRL_SOFTCLR];
        freeze <= wbReq.dat[CTRL_FREEZE];
      end
    end
  end

  // A new overflow beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stickyOv <= 1'b0;
    end else if (overflow) begin
      stickyOv <= 1'b1;
    end else if (stickyClr) begin
      stickyOv <= 1'b0;
    end
  end

  always_comb begin
    rdNext = '0;
    unique case (wbReq.adr)
      ADR_CTRL: begin
        rdNext[CTRL_FREEZE] = freeze;
      end
      ADR_STATUS: begin
        rdNext[ST_OV] = overflow;
        rdNext[ST_STICKY] = stickyOv;
      end
      ADR_RESULT: begin
        rdNext = WB_DW'({{WB_DW{1'b0}}, result});
      end
      default: begin
        rdNext = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbDatOut <= '0;
    end else if (wbHit && !wbReq.we) begin
      wbDatOut <= rdNext;
    end
  end

  logic outClr;
  logic outEn;
  assign outEn = clkEn[OUT_REG.clk];
  assign outClr = ((OUT_REG.clr < CLR_NONE) &&
    ((OUT_REG.clr != CLR_FOURTH) || HAS_CLEAR3)) ?
    asyncClear[OUT_REG.clr[1:0]] : 1'b0;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_ACK_PULSE:
    assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  AST_ACK_TIME:
    assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("bus request not answered next cycle");
  AST_STICKY_SET:
    assert property (overflow |=> stickyOv)
    else $error("sticky overflow missed an overflow");
  AST_SAT_VALUE:
    assert property (overflow |-> (result == posMax) || (result == ~posMax))
    else $error("overflowed result not saturated");
  AST_NO_SAT_FLAG:
    assert property (!SATURATE |-> !overflow)
    else $error("overflow raised with saturation off");
  AST_OUT_HOLD:
    assert property (OUT_REG.used && !outEn && !syncClear && !outClr
      ##1 !outClr |-> $stable(outQ))
    else $error("output register moved without enable");
  AST_OUT_CLEAR:
    assert property (OUT_REG.used && outClr |-> (outQ == '0))
    else $error("asserted clear did not zero output");
  AST_OUT_CAPTURE:
    assert property (OUT_REG.used && outEn && !syncClear && !outClr
      ##1 !outClr |-> outQ == $past(outNext))
    else $error("output register missed enabled capture");
  AST_SOFT_CLEAR:
    assert property (softClear && OUT_REG.used |=> outClr || (outQ == '0))
    else $error("software clear did not zero output");
  AST_PASS:
    assert property (!OUT_REG.used && !softClear ##1 !OUT_REG.used
      |-> outQ == outNext)
    else $error("absent output register not transparent");

  COV_OVERFLOW:
    cover property (overflow ##1 stickyOv);
  COV_WRITE:
    cover property (wbWrite ##1 wbAck);
  COV_READ_STATUS:
    cover property (wbHit && !wbReq.we && (wbReq.adr == ADR_STATUS)
      ##1 wbAck);
endmodule : cma_multiply_adder
`default_nettype wire

// ### hdl/cma_pkg.sv
// Constants and types shared by the configurable multiply-adder
`default_nettype none
package cma_pkg;
  localparam int MAX_MULT = 4;
  localparam int NUM_CLK = 4;
  localparam logic [2:0] CLR_FOURTH = 3'h3;
  localparam logic [2:0] CLR_NONE = 3'h4;

  typedef enum logic [1:0] {REP_UNSIGNED, REP_SIGNED, REP_VARIABLE} cma_rep_t;
  typedef enum logic [1:0] {DIR_ADD, DIR_SUB, DIR_VARIABLE} cma_dir_t;

  // One optional register: present, clock tick index, clear index
  typedef struct packed {
    logic used;
    logic [1:0] clk;
    logic [2:0] clr;
  } cma_reg_t;

  localparam cma_reg_t REG_OFF = '{used: 1'b0, clk: 2'h0, clr: CLR_NONE};

  localparam int CTL_SIGN_A = 0;
  localparam int CTL_SIGN_B = 1;
  localparam int CTL_FIRST = 2;
  localparam int CTL_SECOND = 3;
  localparam int NUM_CTL = 4;

  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WB_SW = 4;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_AW-1:0] adr;
    logic [WB_SW-1:0] sel;
    logic [WB_DW-1:0] dat;
  } cma_wb_req_t;

  localparam logic [WB_AW-1:0] ADR_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] ADR_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] ADR_RESULT = 8'h08;
  localparam int CTRL_SOFTCLR = 0;
  localparam int CTRL_FREEZE = 1;
  localparam int ST_OV = 0;
  localparam int ST_STICKY = 1;
endpackage : cma_pkg
`default_nettype wire

// ### verif/cma_user_model.sv
// Fabric-side stand-in that feeds operands and controls to the block
`default_nettype none
module cma_user_model (
  input wire logic sys_clk,
  input wire logic [31:0] nextA,
  input wire logic [31:0] nextB,
  input wire logic [3:0] nextCtl,
  output var logic [31:0] dataA = 32'h0,
  output var logic [31:0] dataB = 32'h0,
  output var logic signA = 1'b0,
  output var logic signB = 1'b0,
  output var logic firstPair = 1'b0,
  output var logic secondPair = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered like real fabric logic, so values move only after an edge
  always @(posedge sys_clk) begin
    dataA <= nextA;
    dataB <= nextB;
    {signA, signB, firstPair, secondPair} <= nextCtl;
  end
endmodule : cma_user_model
`default_nettype wire

// ### verif/test_cma_multiply_adder.sv
// Self-checking bench for the configurable multiply-adder
`default_nettype none
module test_cma_multiply_adder;
  timeunit 1ns;
  timeprecision 1ns;
  import cma_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [3:0] ctl;
    logic [17:0] res;
    logic ov;
  } cma_row_t;
  localparam cma_reg_t OUT_CFG = '{used: 1'b1, clk: 2'h0, clr: 3'h0};
  localparam int OPW = 8;
  localparam int RW = 18;
  logic sys_clk;
  logic rst;
  logic [3:0] clockTick;
  logic [3:0] clockEnable;
  logic [3:0] asyncClear;
  logic [31:0] nextA;
  logic [31:0] nextB;
  logic [3:0] nextCtl;
  logic [31:0] dataA;
  logic [31:0] dataB;
  logic signA;
  logic signB;
  logic firstPair;
  logic secondPair;
  logic [17:0] result;
  logic overflow;
  logic [7:0] shiftOutA;
  logic [7:0] shiftOutB;
  cma_wb_req_t wbReq;
  logic wbAck;
  logic [31:0] wbDatOut;
  logic [31:0] rd;
  logic [7:0] shiftInA;
  logic [7:0] shiftInB;
  logic [17:0] satResult;
  logic satOverflow;
  logic [31:0] satDat;
  logic [17:0] satExp;
  int fails;
  int checked;
  cma_row_t rows [8];

  `define CHK(name, exp, got) begin checked++; \
    if ((got) !== (exp)) begin fails++; \
    $display("BAD %s exp %h got %h", name, exp, got); end end

  cma_user_model fabric (.sys_clk(sys_clk), .nextA(nextA), .nextB(nextB),
    .nextCtl(nextCtl), .dataA(dataA), .dataB(dataB), .signA(signA),
    .signB(signB), .firstPair(firstPair), .secondPair(secondPair));

  cma_multiply_adder #(.A_WIDTH(OPW), .B_WIDTH(OPW), .R_WIDTH(RW),
    .REP_A(REP_VARIABLE), .REP_B(REP_VARIABLE), .DIR_FIRST(DIR_VARIABLE),
    .DIR_SECOND(DIR_VARIABLE), .OUT_REG(OUT_CFG), .SHIFT_OUT_A(1'b1),
    .SHIFT_OUT_B(1'b1)) uut (
    .sys_clk(sys_clk), .rst(rst), .clockTick(clockTick),
    .clockEnable(clockEnable), .asyncClear(asyncClear), .dataA(dataA),
    .dataB(dataB), .shiftInA(shiftInA), .shiftInB(shiftInB), .signA(signA),
    .signB(signB), .firstPairAddNotSub(firstPair),
    .secondPairAddNotSub(secondPair), .result(result), .overflow(overflow),
    .shiftOutA(shiftOutA), .shiftOutB(shiftOutB), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut));

  // Same inputs, no output register, saturation on
  cma_multiply_adder #(.A_WIDTH(OPW), .B_WIDTH(OPW), .R_WIDTH(RW),
    .REP_A(REP_VARIABLE), .REP_B(REP_VARIABLE), .DIR_FIRST(DIR_VARIABLE),
    .DIR_SECOND(DIR_VARIABLE), .SATURATE(1'b1)) uutSat (
    .sys_clk(sys_clk), .rst(rst), .clockTick(clockTick),
    .clockEnable(clockEnable), .asyncClear(asyncClear), .dataA(dataA),
    .dataB(dataB), .shiftInA(shiftInA), .shiftInB(shiftInB), .signA(signA),
    .signB(signB), .firstPairAddNotSub(firstPair),
    .secondPairAddNotSub(secondPair), .result(satResult),
    .overflow(satOverflow), .shiftOutA(), .shiftOutB(), .wbReq(wbReq),
    .wbAck(), .wbDatOut(satDat));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic results;
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Entered right after a rising edge; no cycle count is assumed
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: dat};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatOut;
    if (n >= 20) fails++;
    wbReq <= '0;
    @(posedge sys_clk);
  endtask : wb

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    results();
  end

  initial begin
    rows[0] = '{32'h04030201, 32'h01010101, 4'b0011, 18'h0000a, 1'b0};
    rows[1] = '{32'h04030201, 32'h01010101, 4'b0000, 18'h3fffe, 1'b0};
    rows[2] = '{32'h000000ff, 32'h00000002, 4'b1011, 18'h3fffe, 1'b0};
    rows[3] = '{32'h000000ff, 32'h00000002, 4'b0011, 18'h001fe, 1'b0};
    rows[4] = '{32'h000000ff, 32'h000000ff, 4'b1111, 18'h00001, 1'b0};
    rows[5] = '{32'h000000ff, 32'h000000ff, 4'b0111, 18'h3ff01, 1'b0};
    rows[6] = '{32'hffffffff, 32'hffffffff, 4'b1100, 18'h00000, 1'b0};
    rows[7] = '{32'hffffffff, 32'hffffffff, 4'b0011, 18'h3f804, 1'b1};
    fails = 0;
    checked = 0;
    rst = 1'b1;
    clockTick = 4'h1;
    clockEnable = 4'h1;
    asyncClear = 4'h0;
    nextA = 32'h0;
    nextB = 32'h0;
    nextCtl = 4'h0;
    shiftInA = 8'h00;
    shiftInB = 8'h00;
    wbReq = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      nextA <= rows[i].a;
      nextB <= rows[i].b;
      nextCtl <= rows[i].ctl;
      settle();
      `CHK("result", rows[i].res, result)
      `CHK("shiftOutA", rows[i].a[31:24], shiftOutA)
      `CHK("shiftOutB", rows[i].b[31:24], shiftOutB)
      `CHK("overflow", 1'b0, overflow)
      // Signed range of 18 bits tops out at 1ffff
      satExp = rows[i].ov ? 18'h1ffff : rows[i].res;
      `CHK("satResult", satExp, satResult)
      `CHK("satOverflow", rows[i].ov, satOverflow)
      @(posedge sys_clk);
    end
    wb(1'b0, ADR_RESULT, 32'h0);
    `CHK("resultReg", 32'h0003f804, rd)
    // Enable low with new operands: output stage must not move
    clockEnable <= 4'h0;
    nextA <= 32'h04030201;
    settle();
    `CHK("hold", 18'h3f804, result)
    @(posedge sys_clk);
    asyncClear <= 4'h2;
    #1;
    `CHK("otherClear", 18'h3f804, result)
    @(posedge sys_clk);
    asyncClear <= 4'h1;
    #1;
    `CHK("asyncClear", 18'h00000, result)
    @(posedge sys_clk);
    asyncClear <= 4'h0;
    clockEnable <= 4'h1;
    settle();
    `CHK("reload", 18'h009f6, result)
    @(posedge sys_clk);
    wb(1'b1, ADR_CTRL, 32'h2);
    nextA <= 32'hffffffff;
    settle();
    `CHK("freeze", 18'h009f6, result)
    @(posedge sys_clk);
    wb(1'b1, ADR_CTRL, 32'h3);
    #1;
    `CHK("softClear", 18'h00000, result)
    @(posedge sys_clk);
    wb(1'b0, ADR_CTRL, 32'h0);
    `CHK("ctrlRead", 32'h00000002, rd)
    wb(1'b1, ADR_CTRL, 32'h0);
    settle();
    `CHK("thaw", 18'h3f804, result)
    @(posedge sys_clk);
    // Ticks only on clock 1: stage on clock 0 must hold
    clockTick <= 4'h2;
    nextA <= 32'h04030201;
    settle();
    `CHK("tickOther", 18'h3f804, result)
    @(posedge sys_clk);
    clockTick <= 4'h1;
    settle();
    `CHK("tickBack", 18'h009f6, result)
    @(posedge sys_clk);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b0, ADR_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    `CHK("satStatus", 32'h2, satDat)
    wb(1'b1, ADR_STATUS, 32'h2);
    wb(1'b0, ADR_STATUS, 32'h0);
    `CHK("stickyClear", 32'h0, satDat)
    results();
  end
endmodule : test_cma_multiply_adder
`default_nettype wire
